// ===== port_pkg.sv
// Shared constants and carrier types for the root port status and control block
package port_pkg;

   // ***********************
   // Register field layout
   // ***********************
   localparam int unsigned REG_W       = 16;
   localparam int unsigned ADDR_W      = 4;
   localparam logic [3:0]  PORT_ADDR   = 4'h0;   // Word index of the port register
   localparam int unsigned B_SUSPEND   = 12;
   localparam int unsigned B_PRESET    = 9;
   localparam int unsigned B_LOWSPEED  = 8;
   localparam int unsigned B_ONE       = 7;
   localparam int unsigned B_RESUME    = 6;
   localparam int unsigned B_DMINUS    = 5;
   localparam int unsigned B_DPLUS     = 4;
   localparam int unsigned B_ENCHG     = 3;
   localparam int unsigned B_ENABLE    = 2;
   localparam int unsigned B_CONCHG    = 1;
   localparam int unsigned B_CONNECT   = 0;
   localparam logic [15:0] UNMAPPED_RD = 16'h0000;

   // ***********************
   // Timing
   // ***********************
   localparam int unsigned CLK_MHZ       = 125;
   localparam int unsigned LS_BIT_NS     = 667;   // One low speed bit time, rounded up
   localparam int unsigned LS_BIT_CYC    = (LS_BIT_NS * CLK_MHZ + 999) / 1000;
   localparam logic [3:0]  EOP_SE0_BITS  = 4'h2;  // Low speed EOP: two bits SE0
   localparam logic [3:0]  EOP_J_BITS    = 4'h1;  // then one bit J
   localparam logic [1:0]  LINE_SE0      = 2'h0;  // Reset value of line status

   // Drive requests toward the port transceiver
   typedef enum logic [2:0] {
      DRV_IDLE = 3'b000,
      DRV_SE0  = 3'b001,
      DRV_K    = 3'b010,
      DRV_J    = 3'b011
   } line_drive_e;

   // Register bus request
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [REG_W-1:0]  wdata;
      logic              wr;
      logic              rd;
   } bus_req_s;

   // Sampled port lines
   typedef struct packed {
      logic dplus;
      logic dminus;
   } line_s;

endpackage : port_pkg

// ===== resume_eop_gen.sv
// Low speed end-of-packet generator that terminates resume signalling
`timescale 1ns/1ps
module resume_eop_gen
   import port_pkg::*;
(
   input  wire logic clk_i,    // Controller clock
   input  wire logic rst_i,    // Synchronous reset
   input  wire logic start_i,  // One-cycle request to send the EOP
   output logic      busy_o,   // High while the EOP is on the lines
   output logic      se0_o,    // High during the SE0 part
   output logic      jst_o     // High during the trailing J bit
);

   logic [7:0] bit_cnt_q;   // Cycles within one bit time
   logic [3:0] bits_q;      // Bit times sent so far
   logic       busy_q;
   wire        bit_end  = (bit_cnt_q == 8'(LS_BIT_CYC - 1));
   wire        last_bit = (bits_q == EOP_SE0_BITS + EOP_J_BITS - 4'h1);

   // Sequencer: SE0 for two low speed bits then J for one
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         busy_q    <= 1'b0;
         bit_cnt_q <= 8'h00;
         bits_q    <= 4'h0;
      end else if (start_i && !busy_q) begin
         busy_q    <= 1'b1;
         bit_cnt_q <= 8'h00;
         bits_q    <= 4'h0;
      end else if (busy_q) begin
         bit_cnt_q <= bit_end ? 8'h00 : bit_cnt_q + 8'h01;
         if (bit_end) begin
            bits_q <= bits_q + 4'h1;
            if (last_bit) begin
               busy_q <= 1'b0;
            end
         end
      end
   end

   assign busy_o = busy_q;
   assign se0_o  = busy_q && (bits_q < EOP_SE0_BITS);
   assign jst_o  = busy_q && (bits_q >= EOP_SE0_BITS);

endmodule : resume_eop_gen

// ===== line_edge_detect.sv
// Line status capture at the frame end check point and J-to-K detection
`timescale 1ns/1ps
module line_edge_detect
   import port_pkg::*;
(
   input  wire logic  clk_i,         // Controller clock
   input  wire logic  rst_i,         // Synchronous reset
   input  line_s      line_i,        // Present D+ and D- levels
   input  wire logic  low_speed_i,   // Low speed device sets J polarity
   input  wire logic  frame_end_i,   // Frame end check point pulse
   output logic [1:0] line_stat_o,   // Latched {D-, D+}
   output logic       j_to_k_o       // Pulse on a J to K transition
);

   logic [1:0] stat_q;
   logic       was_j_q;
   // Full speed J is D+ high, low speed J is D- high; K is the opposite
   wire        is_j = low_speed_i ? (line_i.dminus && !line_i.dplus)
                                  : (line_i.dplus && !line_i.dminus);
   wire        is_k = low_speed_i ? (line_i.dplus && !line_i.dminus)
                                  : (line_i.dminus && !line_i.dplus);

   // Line status only refreshes at the check point so software sees a stable value
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stat_q  <= LINE_SE0;
         was_j_q <= 1'b0;
      end else begin
         if (frame_end_i) begin
            stat_q <= {line_i.dminus, line_i.dplus};   // R15
         end
         was_j_q <= is_j;
      end
   end

   assign line_stat_o = stat_q;
   assign j_to_k_o    = was_j_q && is_k;

endmodule : line_edge_detect

// ===== usb_root_port_status_control.sv
// Root hub port status and control register with suspend, reset and resume logic
//
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/1ps
// How it works
// [R1] Software writes zeros to bits 15:13; they are ignored and read zero.
// [R2] Bit 12 is the suspend bit, reads 1 only while port is suspended; here it stays 1 if the port is disabled while suspended.
// [R3] Software must not set suspend while global suspend is active.
// [R4] Port state comes from suspend and enable: x0 off, 01 on, 11 suspended.
// [R5] Suspended port blocks downstream data; reset SE0 still passes.
// [R6] Suspend taken only after current transaction ends; bit shows it then.
// [R7] Suspended port still reacts to resume from the attached device.
// [R8] Port reset bit 9 holds port disabled and drives SE0 reset.
// [R9] Software times the port reset length; hardware does not.
// [R10] Bit 8 reports low speed device, read only.
// [R11] Bit 7 always reads as 1.
// [R12] Bit 6 set on J to K while suspended, or by software for resume.
// [R13] While bit 6 and suspended, drive K on the port.
// [R14] Clearing bit 6 sends a low speed EOP; bit reads 1 until done.
// [R15] Bits 5:4 show D- and D+, refreshed at the frame end check point.
// [R16] Enable change bit 3 set only when hardware disables the port.
// [R17] Writing 1 to bit 3 clears it; writing 0 leaves it.
// [R18] Enable bit 2 set only by software; cleared by fault or software.
// [R19] Enable bit changes only after the port changes; disable waits for transaction.
// [R20] After reset: no device, port disabled, line status 00.
// [R21] In global suspend, setting bits 6, 3 or 1 signals controller resume.
// [R22] Connect change bit 1 set on connect change, cleared by writing 1.
// [R23] Bit 0 shows a device is present.
// [R24] Bits 11 and 10 ignore writes and read zero.
module usb_root_port_status_control
   import port_pkg::*;
(
   input  wire logic        clk_i,           // Controller clock, 125 MHz
   input  wire logic        rst_i,           // Synchronous reset, active high
   input  bus_req_s         bus_i,           // Register bus request
   output logic [REG_W-1:0] rdata_o,         // Read data, cycle after read strobe
   input  line_s            line_i,          // Sampled D+ and D- levels
   input  wire logic        attach_i,        // Device presence from the detector
   input  wire logic        low_speed_i,     // Attached device is low speed
   input  wire logic        global_susp_i,   // Global suspend bit of host_command_register
   input  wire logic        frame_end_i,     // frame_end_check_point pulse
   input  wire logic        xact_busy_i,     // A transaction is in progress
   input  wire logic        fault_i,         // Port fault seen at the check point
   input  wire logic        data_valid_i,    // Downstream data to send
   input  wire logic        data_se0_i,      // Downstream data bit is SE0
   input  wire logic        data_dp_i,       // Downstream data D+ level
   output logic             drive_oe_o,      // Port transceiver drives the lines
   output logic             drive_dp_o,      // Driven D+ level
   output logic             drive_dm_o,      // Driven D- level
   output logic             port_state_o,    // 1 while the port passes data
   output logic             ctrl_resume_o    // Pulse: request controller resume
);

   // ***********************
   // State and decode
   // ***********************
   typedef enum logic [1:0] {
      PS_DISABLED  = 2'b00,
      PS_ENABLED   = 2'b01,
      PS_SUSPENDED = 2'b11
   } port_state_e;

   logic        suspend_q;       // Suspend reads 1 only once actually suspended
   logic        susp_req_q;      // Software wish to suspend
   logic        enable_q;
   logic        dis_req_q;       // Software wish to disable, waits for transaction
   logic        preset_q;
   logic        resume_q;
   logic        enchg_q;
   logic        conchg_q;
   logic        connect_q;
   logic [15:0] rdata_q;
   logic        oe_q;
   logic        dp_q;
   logic        dm_q;
   logic        pass_q;
   logic        cres_q;
   logic        fault_pend_q;    // Fault seen at check point, waits for transaction
   logic        susp_hold;       // Resume held by software or by a wake

   wire         wr_hit = bus_i.wr && (bus_i.addr == PORT_ADDR);
   wire         rd_hit = bus_i.rd && (bus_i.addr == PORT_ADDR);
   wire [15:0]  wd     = bus_i.wdata;

   wire [1:0]   line_stat;
   wire         j_to_k;
   wire         eop_busy;
   wire         eop_se0;
   wire         eop_j;

   // Port state from the two stored bits
   wire [1:0]   state_bits = {suspend_q, enable_q};              // R4
   wire         st_enabled = (state_bits == PS_ENABLED);
   wire         st_susp    = (state_bits == PS_SUSPENDED);

   // Hardware disable on disconnect or check point fault; a fault waits past a transaction, a disconnect seen during one is not acted on
   wire         disconnect = connect_q && !attach_i;
   wire         hw_disable = enable_q && !xact_busy_i && (disconnect || fault_pend_q);

   // Software clear of resume starts the EOP; bit stays up until it ends
   wire         resume_fall = wr_hit && resume_q && !wd[B_RESUME];
   wire         eop_start   = resume_fall && !eop_busy;          // R14

   // J to K while suspended is a remote wake
   wire         wake = st_susp && j_to_k;                        // R7 R12

   // ***********************
   // Helpers
   // ***********************
   line_edge_detect u_line (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .line_i      (line_i),
      .low_speed_i (low_speed_i),
      .frame_end_i (frame_end_i),
      .line_stat_o (line_stat),
      .j_to_k_o    (j_to_k)
   );

   resume_eop_gen u_eop (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .start_i (eop_start),
      .busy_o  (eop_busy),
      .se0_o   (eop_se0),
      .jst_o   (eop_j)
   );

   // ***********************
   // Suspend and enable
   // ***********************
   // Requests from software are held until the bus is idle so no packet is cut
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         susp_req_q   <= 1'b0;
         dis_req_q    <= 1'b0;
         fault_pend_q <= 1'b0;
      end else begin
         if (wr_hit) begin
            susp_req_q <= wd[B_SUSPEND];                         // R3
            dis_req_q  <= !wd[B_ENABLE] && enable_q;
         end else if (!xact_busy_i) begin
            dis_req_q  <= 1'b0;
         end
         if (frame_end_i && fault_i && enable_q) begin
            fault_pend_q <= 1'b1;
         end else if (!enable_q) begin
            fault_pend_q <= 1'b0;
         end
      end
   end

   // Stored bits move only once the port itself has moved
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         enable_q  <= 1'b0;                                      // R20
         suspend_q <= 1'b0;
      end else begin
         if (preset_q || hw_disable || (wr_hit && wd[B_PRESET])) begin
            enable_q <= 1'b0;                                    // R8 R18
         end else if (wr_hit && wd[B_ENABLE] && !wd[B_PRESET]) begin
            enable_q <= 1'b1;                                    // R18
         end else if (dis_req_q && !xact_busy_i) begin
            enable_q <= 1'b0;                                    // R19
         end
         if (wr_hit && !wd[B_SUSPEND]) begin
            suspend_q <= 1'b0;
         end else if (susp_req_q && enable_q && !xact_busy_i) begin
            suspend_q <= 1'b1;                                   // R2 R6
         end
      end
   end

   // ***********************
   // Reset, resume and change flags
   // ***********************
   // Hardware set wins over a software clear in the same cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         preset_q  <= 1'b0;
         resume_q  <= 1'b0;
         enchg_q   <= 1'b0;
         conchg_q  <= 1'b0;
         connect_q <= 1'b0;                                      // R20
      end else begin
         if (wr_hit) begin
            preset_q <= wd[B_PRESET];                            // R8 R9
         end
         if (wake || (wr_hit && wd[B_RESUME])) begin
            resume_q <= 1'b1;                                    // R12
         end else if (!eop_busy && !eop_start && resume_fall) begin
            resume_q <= resume_q;                                // EOP not yet begun
         end else if (eop_busy && !eop_start) begin
            resume_q <= 1'b1;                                    // R14
         end else if (!eop_busy && resume_q && !susp_hold) begin
            resume_q <= 1'b0;
         end
         if (hw_disable) begin
            enchg_q <= 1'b1;                                     // R16
         end else if (wr_hit && wd[B_ENCHG]) begin
            enchg_q <= 1'b0;                                     // R17
         end
         connect_q <= attach_i;                                  // R23
         if (connect_q != attach_i) begin
            conchg_q <= 1'b1;                                    // R22
         end else if (wr_hit && wd[B_CONCHG]) begin
            conchg_q <= 1'b0;
         end
      end
   end

   // Resume stays set until software clears it and any EOP has finished
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         susp_hold <= 1'b0;
      end else if (wr_hit) begin
         susp_hold <= wd[B_RESUME];
      end else if (wake) begin
         susp_hold <= 1'b1;
      end
   end

   // ***********************
   // Line drive
   // ***********************
   // Reset SE0 overrides all; resume K and EOP next, though a data SE0 beats the EOP J; data only while enabled
   wire drv_reset = preset_q;                                    // R5 R8
   wire drv_k     = resume_q && suspend_q && !eop_busy;          // R13
   wire drv_data  = st_enabled && data_valid_i;                  // R5
   wire drv_se0   = drv_reset || eop_se0 || (drv_data && data_se0_i);
   wire j_dp      = !low_speed_i;
   wire k_dp      = low_speed_i;
   wire nxt_oe    = drv_reset || eop_busy || drv_k || drv_data;
   wire nxt_dp    = drv_se0 ? 1'b0 :
                    eop_j   ? j_dp :
                    drv_k   ? k_dp : data_dp_i;
   wire nxt_dm    = drv_se0 ? 1'b0 :
                    eop_j   ? !j_dp :
                    drv_k   ? !k_dp : !data_dp_i;

   // Controller resume only matters while globally suspended
   wire new_evt   = (wake && !resume_q) || (hw_disable && !enchg_q)
                    || ((connect_q != attach_i) && !conchg_q);   // R21

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         oe_q   <= 1'b0;
         dp_q   <= 1'b0;
         dm_q   <= 1'b0;
         pass_q <= 1'b0;
         cres_q <= 1'b0;
      end else begin
         oe_q   <= nxt_oe;
         dp_q   <= nxt_dp;
         dm_q   <= nxt_dm;
         pass_q <= st_enabled;
         cres_q <= global_susp_i && new_evt;                     // R21
      end
   end

   // ***********************
   // Register read
   // ***********************
   // Reserved high bits and 11:10 read zero; bit 7 reads one
   wire [15:0] port_word;
   assign port_word[15:13]    = 3'h0;                            // R1
   assign port_word[12]       = suspend_q;                       // R2
   assign port_word[11:10]    = 2'h0;                            // R24
   assign port_word[9]        = preset_q;
   assign port_word[8]        = low_speed_i;                     // R10
   assign port_word[7]        = 1'b1;                            // R11
   assign port_word[6]        = resume_q;
   assign port_word[5:4]      = line_stat;                       // R15
   assign port_word[3]        = enchg_q;
   assign port_word[2]        = enable_q;
   assign port_word[1]        = conchg_q;
   assign port_word[0]        = connect_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_q <= UNMAPPED_RD;
      end else if (rd_hit) begin
         rdata_q <= port_word;
      end else begin
         rdata_q <= UNMAPPED_RD;
      end
   end

   assign rdata_o       = rdata_q;
   assign drive_oe_o    = oe_q;
   assign drive_dp_o    = dp_q;
   assign drive_dm_o    = dm_q;
   assign port_state_o  = pass_q;
   assign ctrl_resume_o = cres_q;

endmodule : usb_root_port_status_control

// ===== port_ctrl_assertions.sv
// Concurrent checks on the ports of the root port status and control block
`timescale 1ns/1ps
module port_ctrl_checker
   import port_pkg::*;
(
   input  wire logic             clk_i,          // Controller clock
   input  wire logic             rst_i,          // Synchronous reset
   input  bus_req_s              bus_i,          // Register bus request
   input  wire logic [REG_W-1:0] rdata_o,        // Read data
   input  wire logic             attach_i,       // Device present
   input  wire logic             low_speed_i,    // Low speed device
   input  wire logic             global_susp_i,  // Global suspend
   input  wire logic             xact_busy_i,    // Transaction in progress
   input  wire logic             data_valid_i,   // Downstream bit valid
   input  wire logic             data_se0_i,     // Downstream bit is SE0
   input  wire logic             data_dp_i,      // Downstream D+ level
   input  wire logic             drive_oe_o,     // Line drive enable
   input  wire logic             drive_dp_o,     // Driven D+
   input  wire logic             drive_dm_o,     // Driven D-
   input  wire logic             port_state_o,   // Port passes data
   input  wire logic             ctrl_resume_o   // Controller resume pulse
);
   // ***********************
   // Helper logic
   // ***********************
   logic preset_q;
   wire  rd_port = bus_i.rd && (bus_i.addr == PORT_ADDR);

   // Shadow of the port reset bit; only software moves it, so writes tell all
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         preset_q <= 1'b0;
      end else if (bus_i.wr && bus_i.addr == PORT_ADDR) begin
         preset_q <= bus_i.wdata[B_PRESET];
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // ***********************
   // Properties
   // ***********************
   a_fixed_bits: assert property ($past(rd_port) |-> rdata_o[15:13] == 3'h0
      && rdata_o[11:10] == 2'h0 && rdata_o[B_ONE]) else $error("Fixed bits read wrong");
   a_low_speed: assert property ($past(rd_port) |->
      rdata_o[B_LOWSPEED] == $past(low_speed_i)) else $error("Speed bit wrong");
   a_state_map: assert property ($past(rd_port) && $past(port_state_o) && port_state_o
      |-> rdata_o[B_ENABLE] && !rdata_o[B_SUSPEND]) else $error("Port state mismatch");
   a_port_reset: assert property (preset_q && $past(preset_q) |-> drive_oe_o
      && !drive_dp_o && !drive_dm_o && !port_state_o) else $error("Port reset not driven");
   // Busy for three edges with the device present: no disable may land
   a_busy_hold: assert property (xact_busy_i && $past(xact_busy_i) && $past(xact_busy_i, 2)
      && attach_i && $past(attach_i, 2) && !$past(preset_q) |-> !$fell(port_state_o))
      else $error("Port stopped during a transaction");
   a_resume_req: assert property ($rose(ctrl_resume_o) |-> $past(global_susp_i))
      else $error("Resume request outside global suspend");
   a_resume_once: assert property (ctrl_resume_o |=> !ctrl_resume_o)
      else $error("Resume request longer than one cycle");
   a_data_pass: assert property (data_valid_i && !data_se0_i && !preset_q ##1 port_state_o
      |-> drive_oe_o && drive_dp_o == $past(data_dp_i)
      && drive_dm_o != $past(data_dp_i)) else $error("Downstream data not passed");
endmodule : port_ctrl_checker

// ===== usb_dev_model.sv
// Behavioural model of the device plugged into the root port
`timescale 1ns/1ps
module usb_dev_model
   import port_pkg::*;
(
   input  wire logic attach_en_i,  // Device plugged in
   input  wire logic ls_en_i,      // Device is low speed
   input  wire logic resume_en_i,  // Device signals resume (K)
   input  wire logic host_oe_i,    // Host drives the lines
   input  wire logic host_dp_i,    // Host D+
   input  wire logic host_dm_i,    // Host D-
   output line_s     line_o,       // Resolved line levels
   output logic      attach_o,     // Presence seen by the host
   output logic      low_speed_o   // Speed seen by the host
);
   // Idle J polarity follows speed; pull-downs give SE0 when unplugged
   wire j_dp = !ls_en_i;
   assign attach_o    = attach_en_i;
   assign low_speed_o = attach_en_i && ls_en_i;
   // Host wins while it drives, else the device idles J or sends K
   assign line_o = host_oe_i ? line_s'({host_dp_i, host_dm_i}) :
                   !attach_en_i ? line_s'(2'h0) :
                   resume_en_i ? line_s'({!j_dp, j_dp}) :
                   line_s'({j_dp, !j_dp});
endmodule : usb_dev_model

// ===== tb_top.sv
// Self-checking bench for the root port status and control block
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_mismatch++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_top
   import port_pkg::*;
;
   typedef struct packed {logic [15:0] wd; logic [15:0] ex; logic st;} row_s;
   logic clk_i, rst_i, attach_i, low_speed_i, global_susp_i, frame_end_i, xact_busy_i, fault_i;
   logic data_valid_i, data_se0_i, data_dp_i, drive_oe_o, drive_dp_o, drive_dm_o;
   logic port_state_o, ctrl_resume_o, dev_on, dev_res;
   bus_req_s   bus_i;
   line_s      line_i;
   logic [15:0] rdata_o, rd_v;
   int         n_mismatch, tests_run, n_res, cnt_se0, cnt_j;
   // Writes with ignored bits set, then software disable and enable
   row_s rows [5] = '{'{16'h0C04, 16'h01A5, 1'b1}, '{16'h0134, 16'h01A5, 1'b1},
      '{16'h000C, 16'h01A5, 1'b1}, '{16'h0000, 16'h01A1, 1'b0}, '{16'h0004, 16'h01A5, 1'b1}};

   usb_root_port_status_control dut (.clk_i(clk_i), .rst_i(rst_i), .bus_i(bus_i),
      .rdata_o(rdata_o), .line_i(line_i), .attach_i(attach_i), .low_speed_i(low_speed_i),
      .global_susp_i(global_susp_i), .frame_end_i(frame_end_i), .xact_busy_i(xact_busy_i),
      .fault_i(fault_i), .data_valid_i(data_valid_i), .data_se0_i(data_se0_i),
      .data_dp_i(data_dp_i), .drive_oe_o(drive_oe_o), .drive_dp_o(drive_dp_o),
      .drive_dm_o(drive_dm_o), .port_state_o(port_state_o), .ctrl_resume_o(ctrl_resume_o));
   usb_dev_model dev (.attach_en_i(dev_on), .ls_en_i(1'b1), .resume_en_i(dev_res),
      .host_oe_i(drive_oe_o), .host_dp_i(drive_dp_o), .host_dm_i(drive_dm_o),
      .line_o(line_i), .attach_o(attach_i), .low_speed_o(low_speed_i));

   // ***********************
   // Bus tasks
   // ***********************
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_i);
      bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_i);
      bus_i.wr <= 1'b0;
   endtask : wr
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk_i);
      bus_i <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge clk_i) bus_i.rd <= 1'b0;
      @(negedge clk_i) d = rdata_o;
      @(posedge clk_i);
   endtask : rd
   task automatic chk_rd(input logic [15:0] ex);
      rd(PORT_ADDR, rd_v);
      `CHK(rd_v, ex)
   endtask : chk_rd
   task automatic check_point(input logic f);
      @(posedge clk_i);
      frame_end_i <= 1'b1;
      fault_i     <= f;
      @(posedge clk_i);
      frame_end_i <= 1'b0;
      fault_i     <= 1'b0;
   endtask : check_point
   task automatic final_report;
      $display("checks=%0d mismatches=%0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : final_report

   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   // Counts controller resume pulses
   always @(posedge clk_i) if (ctrl_resume_o === 1'b1) n_res++;
   // Whole run is near 550 cycles; a hang is cut well after that
   initial begin
      repeat (8000) @(posedge clk_i);
      n_mismatch++;
      final_report();
   end

   initial begin
      {rst_i, bus_i, global_susp_i, frame_end_i, xact_busy_i, fault_i} = '0;
      {data_valid_i, data_se0_i, data_dp_i, dev_on, dev_res, n_res} = '0;
      rst_i = 1'b1;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      chk_rd(16'h0080);
      rd(4'h1, rd_v);
      `CHK(rd_v, UNMAPPED_RD)
      dev_on <= 1'b1;
      repeat (4) @(posedge clk_i);
      chk_rd(16'h0183);
      wr(PORT_ADDR, 16'h0002);
      chk_rd(16'h0181);
      check_point(1'b0);
      chk_rd(16'h01A1);
      foreach (rows[i]) begin
         wr(PORT_ADDR, rows[i].wd);
         chk_rd(rows[i].ex);
         `CHK(port_state_o, rows[i].st)
      end
      // Data passes, then with data stopped port reset drives SE0
      data_valid_i <= 1'b1;
      data_dp_i    <= 1'b1;
      repeat (2) @(posedge clk_i);
      `CHK({drive_oe_o, drive_dp_o, drive_dm_o}, 3'b110)
      data_valid_i <= 1'b0;
      wr(PORT_ADDR, 16'h0204);
      chk_rd(16'h03A1);
      `CHK({drive_oe_o, drive_dp_o, drive_dm_o, port_state_o}, 4'b1000)
      wr(PORT_ADDR, 16'h0000);
      wr(PORT_ADDR, 16'h0004);
      // Suspend asked mid-transaction waits for it to end
      xact_busy_i <= 1'b1;
      wr(PORT_ADDR, 16'h1004);
      repeat (4) @(posedge clk_i);
      chk_rd(16'h01A5);
      `CHK(port_state_o, 1'b1)
      xact_busy_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      chk_rd(16'h11A5);
      data_valid_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      `CHK({drive_oe_o, port_state_o}, 2'b00)
      data_valid_i <= 1'b0;
      // Device resume while the controller is globally suspended
      global_susp_i <= 1'b1;
      dev_res       <= 1'b1;
      repeat (8) @(posedge clk_i);
      dev_res <= 1'b0;
      chk_rd(16'h11E5);
      `CHK({drive_oe_o, drive_dp_o, drive_dm_o}, 3'b110)
      `CHK(n_res > 0, 1'b1)
      global_susp_i <= 1'b0;
      // Clearing resume and suspend together ends with a low speed EOP
      wr(PORT_ADDR, 16'h0004);
      fork
         repeat (400) begin
            #1;
            if ({drive_oe_o, drive_dp_o, drive_dm_o} === 3'b100) cnt_se0++;
            if ({drive_oe_o, drive_dp_o, drive_dm_o} === 3'b101) cnt_j++;
            @(posedge clk_i);
         end
         begin
            rd(PORT_ADDR, rd_v);
            `CHK(rd_v[B_RESUME], 1'b1)
         end
      join
      `CHK(cnt_se0, int'(EOP_SE0_BITS) * LS_BIT_CYC)
      `CHK(cnt_j, int'(EOP_J_BITS) * LS_BIT_CYC)
      chk_rd(16'h01A5);
      // Disconnect, then the change flags clear one by one
      dev_on <= 1'b0;
      repeat (4) @(posedge clk_i);
      chk_rd(16'h00AA);
      wr(PORT_ADDR, 16'h0008);
      chk_rd(16'h00A2);
      wr(PORT_ADDR, 16'h0002);
      chk_rd(16'h00A0);
      // Fault seen at the check point disables the port
      dev_on <= 1'b1;
      repeat (4) @(posedge clk_i);
      wr(PORT_ADDR, 16'h0006);
      check_point(1'b1);
      repeat (3) @(posedge clk_i);
      chk_rd(16'h01A9);
      final_report();
   end
endmodule : tb_top

bind usb_root_port_status_control port_ctrl_checker u_chk (.clk_i(clk_i), .rst_i(rst_i),
   .bus_i(bus_i), .rdata_o(rdata_o), .attach_i(attach_i), .low_speed_i(low_speed_i),
   .global_susp_i(global_susp_i), .xact_busy_i(xact_busy_i), .data_valid_i(data_valid_i),
   .data_se0_i(data_se0_i), .data_dp_i(data_dp_i), .drive_oe_o(drive_oe_o),
   .drive_dp_o(drive_dp_o), .drive_dm_o(drive_dm_o), .port_state_o(port_state_o),
   .ctrl_resume_o(ctrl_resume_o));
